/* File: bridge_decoder_params.svh */
// constants for the bridge address decoder: offsets, fields, reset values
// assumes inclusion by bare name from the decoder module
`ifndef BRIDGE_DECODER_PARAMS_SVH
`define BRIDGE_DECODER_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_IO_WIN      12'h000
`define OFS_MEM_WIN     12'h004
`define OFS_PMEM_WIN    12'h008
`define OFS_BRIDGE_CTL  12'h00C
`define OFS_MAIN_TOP    12'h010
`define OFS_APERTURE    12'h014
`define OFS_SMM_CTL     12'h018
`define OFS_STATUS      12'h01C
`define OFS_COUNT       12'h020

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IO_LOWER_LSB    0
`define IO_UPPER_LSB    8
`define MEM_LOWER_LSB   0
`define MEM_UPPER_LSB   16
`define CTL_ALIAS_BIT   0
`define CTL_VGA_BIT     1
`define CTL_MONO_BIT    2
`define CTL_IOEN_BIT    3
`define CTL_MEMEN_BIT   4
`define SMM_EN_BIT      0
`define SMM_CSEG_BIT    1

// ----------------------------------------------------------------
// reset values and fixed ranges
// ----------------------------------------------------------------
`define RST_IO_WIN      32'h0000_0F00
`define RST_MEM_WIN     32'h0000_0FFF
`define RST_BRIDGE_CTL  32'h0000_0000
`define RST_MAIN_TOP    12'h000
`define RST_APERTURE    32'h0000_0000
`define RST_SMM_CTL     32'h0000_0000
`define IO_WRAP_FIRST   16'hFFFD
`define VGA_MEM_LO      32'h000A_0000
`define VGA_MEM_HI      32'h000B_FFFF
`define CSEG_LO         32'h000C_0000
`define CSEG_HI         32'h000C_FFFF
`define MONO_IO_LO      10'h3B0
`define MONO_IO_HI      10'h3BB
`define VGA_IO_LO       10'h3C0
`define VGA_IO_HI       10'h3DF
`define CFG_ADDR_PORT   16'h0CF8
`define CFG_DATA_PORT   16'h0CFC

`endif

/* File: bridge_decoder_pkg.sv */
// types for the bridge address decoder
// assumes the params header sits in the same folder
package bridge_decoder_pkg;

  typedef enum logic [1:0] {
    SRC_HOST,
    SRC_PCI,
    SRC_GPORT
  } source_e;

  typedef enum logic [2:0] {
    CMD_MEM_READ,
    CMD_MEM_WRITE,
    CMD_IO_READ,
    CMD_IO_WRITE,
    CMD_CONFIG,
    CMD_SPECIAL
  } command_e;

  typedef enum logic [2:0] {
    ROUTE_NONE,
    ROUTE_MEMORY,
    ROUTE_PCI,
    ROUTE_GPORT,
    ROUTE_DROP,
    ROUTE_LOCAL
  } route_e;

endpackage : bridge_decoder_pkg

/* File: bridge_address_decoder.sv */
// address decode and routing for a host, PCI and graphics-port bridge
// assumes one request per cycle on the request port, APB master on the register side
//
// How it works
// - host I/O goes to PCI unless inside the graphics-port I/O window or at the config ports, which stay local
// - I/O window compares bits 15:12, base low zero, limit low FFFh
// - same I/O window also serves PCI-only agents behind the graphics port
// - one address map serves host, PCI and graphics-port initiators
// - PCI accesses to PCI range unclaimed; memory, window, aperture forwarded
// - PCI cycles into graphics memory windows forwarded only as writes
// - unclaimed PCI cycles end by subtractive decode or master-abort
// - graphics-port frame memory writes always claimed, outside memory go to PCI
// - graphics-port frame reads claimed only in main memory or aperture
// - graphics-port I/O, configuration, special cycles get no response
// - pipelined requests outside memory: reads give arbitrary data, writes dropped
// - legacy VGA memory and I/O routed by bridge control and command bits
// - VGA I/O matches bits 9:0 in 3B0-3BB or 3C0-3DF, upper bits ignored
// - VGA forward clear: graphics port only with alias clear, mono also clear for 3B0-3BB, I/O also only inside window
// - VGA forward set: legacy cycles go to PCI/ISA in every combination
// - mono range may go to PCI while VGA goes to graphics port
// - memory windows compare bits 31:20, base low zero, limit low FFFFFh
// - host I/O addresses pass untranslated over full 64 KB
// - PCI and graphics-port initiators never reach system-management memory
`timescale 1ns/1ps
`include "bridge_decoder_params.svh"

module bridge_address_decoder (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  // register bus
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // request in address phase
  input  wire logic                          reqValid,
  input  wire bridge_decoder_pkg::source_e   reqSource,
  input  wire bridge_decoder_pkg::command_e  reqCommand,
  input  wire logic                          reqPipelined,
  input  wire logic                          reqSmmMode,
  input  wire logic [31:0]                   reqAddr,
  input  wire logic                          host_addr_bit_sixteen,
  // routing answer
  output logic                               routeValid,
  output bridge_decoder_pkg::route_e         routeTarget,
  output logic                               routeClaim,
  output logic [31:0]                        routeAddr
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ioWin_q;
  logic [31:0] memWin_q;
  logic [31:0] pmemWin_q;
  logic [31:0] bridgeCtl_q;
  logic [11:0] mainTop_q;
  logic [31:0] aperture_q;
  logic [31:0] smmCtl_q;
  logic [15:0] lastPci_q;
  logic [15:0] lastGport_q;
  logic [15:0] lastNone_q;

  logic [3:0]  gport_io_window_lower;
  logic [3:0]  gport_io_window_upper;
  logic        legacy_alias_filter;
  logic        vgaForward;
  logic        mono_display_forward;
  logic        ioEnable;
  logic        memEnable;

  assign gport_io_window_lower = ioWin_q[`IO_LOWER_LSB+:4];
  assign gport_io_window_upper = ioWin_q[`IO_UPPER_LSB+:4];
  assign legacy_alias_filter   = bridgeCtl_q[`CTL_ALIAS_BIT];
  assign vgaForward            = bridgeCtl_q[`CTL_VGA_BIT];
  assign mono_display_forward  = bridgeCtl_q[`CTL_MONO_BIT];
  assign ioEnable              = bridgeCtl_q[`CTL_IOEN_BIT];
  assign memEnable             = bridgeCtl_q[`CTL_MEMEN_BIT];

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic inWindow12(input logic [31:0] a, input logic [31:0] w);
    inWindow12 = (a[31:20] >= w[`MEM_LOWER_LSB+:12]) && (a[31:20] <= w[`MEM_UPPER_LSB+:12]);
  endfunction : inWindow12

  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  // ----------------------------------------------------------------
  // address classification
  // ----------------------------------------------------------------
  logic [31:0] ioAddr;
  logic        ioWinHit;
  logic        vgaIoHit;
  logic        monoIoHit;
  logic        vgaMemHit;
  logic        smmHit;
  logic        mainHit;
  logic        apertureHit;
  logic        gportMemHit;
  logic        isIo;
  logic        isWrite;
  logic        cfgPort;

  // bit 16 comes from the host pin so wrapped accesses stay untranslated
  assign ioAddr = {15'h0000, host_addr_bit_sixteen, reqAddr[15:0]};
  assign isIo   = (reqCommand == bridge_decoder_pkg::CMD_IO_READ) ||
                  (reqCommand == bridge_decoder_pkg::CMD_IO_WRITE);
  assign isWrite = (reqCommand == bridge_decoder_pkg::CMD_MEM_WRITE) ||
                   (reqCommand == bridge_decoder_pkg::CMD_IO_WRITE);
  assign cfgPort = (reqAddr[15:2] == 14'(`CFG_ADDR_PORT >> 2)) ||
                   (reqAddr[15:2] == 14'(`CFG_DATA_PORT >> 2));

  // wrapped addresses above 64 KB never hit the graphics-port I/O window
  assign ioWinHit = ioEnable && !host_addr_bit_sixteen &&
                    (reqAddr[15:12] >= gport_io_window_lower) &&
                    (reqAddr[15:12] <= gport_io_window_upper);
  assign monoIoHit = (reqAddr[9:0] >= `MONO_IO_LO) && (reqAddr[9:0] <= `MONO_IO_HI);
  assign vgaIoHit  = monoIoHit ||
                     ((reqAddr[9:0] >= `VGA_IO_LO) && (reqAddr[9:0] <= `VGA_IO_HI));
  assign vgaMemHit = inRange(reqAddr, `VGA_MEM_LO, `VGA_MEM_HI);
  assign smmHit    = smmCtl_q[`SMM_EN_BIT] && (vgaMemHit ||
                     (smmCtl_q[`SMM_CSEG_BIT] && inRange(reqAddr, `CSEG_LO, `CSEG_HI)));
  assign mainHit   = (reqAddr[31:20] < mainTop_q) && !vgaMemHit;
  assign apertureHit = (aperture_q[0] == 1'b1) &&
                       ((reqAddr & aperture_q[31:0] & 32'hFFC0_0000) ==
                        (aperture_q & 32'hFFC0_0000 & aperture_q)) &&
                       (reqAddr[31:22] == aperture_q[31:22]);
  assign gportMemHit = memEnable &&
                       (inWindow12(reqAddr, memWin_q) || inWindow12(reqAddr, pmemWin_q));

  // legacy forwarding per bridge control; mono can stay on PCI alone
  function automatic logic legacyToGport(input logic isMono, input logic inWin);
    if (vgaForward) begin
      legacyToGport = 1'b0;
    end else begin
      legacyToGport = inWin && !legacy_alias_filter &&
                      !(isMono && mono_display_forward);
    end
  endfunction : legacyToGport

  // ----------------------------------------------------------------
  // routing decision
  // ----------------------------------------------------------------
  bridge_decoder_pkg::route_e routeNext;

  // one answer per request from the same map for every source
  always_comb begin
    routeNext = bridge_decoder_pkg::ROUTE_NONE;
    case (reqSource)
      bridge_decoder_pkg::SRC_HOST: begin
        if (isIo) begin
          if (cfgPort && !host_addr_bit_sixteen) begin
            routeNext = bridge_decoder_pkg::ROUTE_LOCAL;
          end else if (vgaIoHit && !host_addr_bit_sixteen) begin
            routeNext = legacyToGport(monoIoHit, ioWinHit) ?
                        bridge_decoder_pkg::ROUTE_GPORT : bridge_decoder_pkg::ROUTE_PCI;
          end else if (ioWinHit) begin
            routeNext = bridge_decoder_pkg::ROUTE_GPORT;
          end else begin
            routeNext = bridge_decoder_pkg::ROUTE_PCI;
          end
        end else if (reqCommand == bridge_decoder_pkg::CMD_CONFIG ||
                     reqCommand == bridge_decoder_pkg::CMD_SPECIAL) begin
          routeNext = bridge_decoder_pkg::ROUTE_PCI;
        end else if (reqSmmMode && smmHit) begin
          routeNext = bridge_decoder_pkg::ROUTE_MEMORY;
        end else if (vgaMemHit) begin
          routeNext = legacyToGport(1'b0, 1'b1) ?
                      bridge_decoder_pkg::ROUTE_GPORT : bridge_decoder_pkg::ROUTE_PCI;
        end else if (mainHit || apertureHit) begin
          routeNext = bridge_decoder_pkg::ROUTE_MEMORY;
        end else if (gportMemHit) begin
          routeNext = bridge_decoder_pkg::ROUTE_GPORT;
        end else begin
          routeNext = bridge_decoder_pkg::ROUTE_PCI;
        end
      end
      bridge_decoder_pkg::SRC_PCI: begin
        if (isIo || reqCommand == bridge_decoder_pkg::CMD_CONFIG ||
            reqCommand == bridge_decoder_pkg::CMD_SPECIAL || smmHit) begin
          routeNext = bridge_decoder_pkg::ROUTE_NONE;
        end else if (mainHit || apertureHit) begin
          routeNext = bridge_decoder_pkg::ROUTE_MEMORY;
        end else if (gportMemHit && isWrite) begin
          routeNext = bridge_decoder_pkg::ROUTE_GPORT;
        end else begin
          routeNext = bridge_decoder_pkg::ROUTE_NONE;
        end
      end
      bridge_decoder_pkg::SRC_GPORT: begin
        if (reqPipelined) begin
          // pipelined and sideband requests are expected in memory only
          if ((mainHit || apertureHit) && !smmHit) begin
            routeNext = bridge_decoder_pkg::ROUTE_MEMORY;
          end else begin
            routeNext = bridge_decoder_pkg::ROUTE_DROP;
          end
        end else if (isIo || reqCommand == bridge_decoder_pkg::CMD_CONFIG ||
                     reqCommand == bridge_decoder_pkg::CMD_SPECIAL) begin
          routeNext = bridge_decoder_pkg::ROUTE_NONE;
        end else if (smmHit) begin
          routeNext = isWrite ? bridge_decoder_pkg::ROUTE_DROP :
                                bridge_decoder_pkg::ROUTE_NONE;
        end else if (mainHit || apertureHit) begin
          routeNext = bridge_decoder_pkg::ROUTE_MEMORY;
        end else if (isWrite) begin
          routeNext = bridge_decoder_pkg::ROUTE_PCI;
        end else begin
          routeNext = bridge_decoder_pkg::ROUTE_NONE;
        end
      end
      default: begin
        routeNext = bridge_decoder_pkg::ROUTE_NONE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // routing outputs, one cycle after the address phase
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      routeValid  <= 1'b0;
      routeTarget <= bridge_decoder_pkg::ROUTE_NONE;
      routeClaim  <= 1'b0;
      routeAddr   <= 32'h0000_0000;
    end else begin
      routeValid  <= reqValid;
      routeTarget <= reqValid ? routeNext : bridge_decoder_pkg::ROUTE_NONE;
      // dropped requests are claimed so reads finish with arbitrary data
      routeClaim  <= reqValid && (routeNext != bridge_decoder_pkg::ROUTE_NONE);
      routeAddr   <= isIo ? ioAddr : reqAddr;
    end
  end

  // ----------------------------------------------------------------
  // route statistics, visible to software
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lastPci_q   <= 16'h0000;
      lastGport_q <= 16'h0000;
      lastNone_q  <= 16'h0000;
    end else if (reqValid) begin
      if (routeNext == bridge_decoder_pkg::ROUTE_PCI) begin
        lastPci_q <= lastPci_q + 16'h0001;
      end
      if (routeNext == bridge_decoder_pkg::ROUTE_GPORT) begin
        lastGport_q <= lastGport_q + 16'h0001;
      end
      if (routeNext == bridge_decoder_pkg::ROUTE_NONE) begin
        lastNone_q <= lastNone_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  logic apbWrite;
  assign apbWrite = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && (paddr > `OFS_COUNT || paddr[1:0] != 2'b00);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ioWin_q     <= `RST_IO_WIN;
      memWin_q    <= `RST_MEM_WIN;
      pmemWin_q   <= `RST_MEM_WIN;
      bridgeCtl_q <= `RST_BRIDGE_CTL;
      mainTop_q   <= `RST_MAIN_TOP;
      aperture_q  <= `RST_APERTURE;
      smmCtl_q    <= `RST_SMM_CTL;
    end else if (apbWrite) begin
      if (paddr == `OFS_IO_WIN) begin
        ioWin_q <= pwdata & 32'h0000_0F0F;
      end else if (paddr == `OFS_MEM_WIN) begin
        memWin_q <= pwdata & 32'h0FFF_0FFF;
      end else if (paddr == `OFS_PMEM_WIN) begin
        pmemWin_q <= pwdata & 32'h0FFF_0FFF;
      end else if (paddr == `OFS_BRIDGE_CTL) begin
        bridgeCtl_q <= pwdata & 32'h0000_001F;
      end else if (paddr == `OFS_MAIN_TOP) begin
        mainTop_q <= pwdata[11:0];
      end else if (paddr == `OFS_APERTURE) begin
        aperture_q <= pwdata & 32'hFFC0_0001;
      end else if (paddr == `OFS_SMM_CTL) begin
        smmCtl_q <= pwdata & 32'h0000_0003;
      end
    end
  end

  always_comb begin
    if (paddr == `OFS_IO_WIN) begin
      prdata = ioWin_q;
    end else if (paddr == `OFS_MEM_WIN) begin
      prdata = memWin_q;
    end else if (paddr == `OFS_PMEM_WIN) begin
      prdata = pmemWin_q;
    end else if (paddr == `OFS_BRIDGE_CTL) begin
      prdata = bridgeCtl_q;
    end else if (paddr == `OFS_MAIN_TOP) begin
      prdata = {20'h00000, mainTop_q};
    end else if (paddr == `OFS_APERTURE) begin
      prdata = aperture_q;
    end else if (paddr == `OFS_SMM_CTL) begin
      prdata = smmCtl_q;
    end else if (paddr == `OFS_STATUS) begin
      prdata = {lastGport_q, lastPci_q};
    end else if (paddr == `OFS_COUNT) begin
      prdata = {16'h0000, lastNone_q};
    end else begin
      prdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  gport_io_nores_a: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqSource == bridge_decoder_pkg::SRC_GPORT && !reqPipelined && isIo
    |=> routeValid && !routeClaim)
    else $error("graphics-port I/O was answered");

  pci_io_nores_a: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqSource == bridge_decoder_pkg::SRC_PCI && isIo |=> !routeClaim)
    else $error("PCI I/O was claimed");

  pci_read_win_a: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqSource == bridge_decoder_pkg::SRC_PCI && !isWrite
    |=> routeTarget != bridge_decoder_pkg::ROUTE_GPORT)
    else $error("PCI read forwarded to graphics port");

  gport_write_claim_a: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqSource == bridge_decoder_pkg::SRC_GPORT && !reqPipelined &&
    reqCommand == bridge_decoder_pkg::CMD_MEM_WRITE |=> routeClaim)
    else $error("graphics-port write not claimed");

  host_io_win_a: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqSource == bridge_decoder_pkg::SRC_HOST && isIo && ioWinHit &&
    !vgaIoHit && !cfgPort |=> routeTarget == bridge_decoder_pkg::ROUTE_GPORT)
    else $error("host I/O window hit not sent to graphics port");

  smm_guard_a: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqSource != bridge_decoder_pkg::SRC_HOST && smmHit
    |=> routeTarget != bridge_decoder_pkg::ROUTE_MEMORY)
    else $error("external initiator reached SMM memory");

  pipe_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && reqSource == bridge_decoder_pkg::SRC_GPORT && reqPipelined &&
    !mainHit && !apertureHit |=> routeTarget == bridge_decoder_pkg::ROUTE_DROP)
    else $error("pipelined request outside memory not dropped");

  io_addr_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
    reqValid && isIo |=> routeAddr[15:0] == $past(reqAddr[15:0]))
    else $error("I/O address translated");

endmodule : bridge_address_decoder

/* File: initiator_model.sv */
// far-side masters: host, PCI and graphics-port initiators presenting address phases
// assumes the bench calls issue and judges the decoder's answer itself
`timescale 1ns/1ps

module initiator_model (
  // clock
  input  wire logic                         clock,
  // request address phase
  output logic                              reqValid,
  output bridge_decoder_pkg::source_e       reqSource,
  output bridge_decoder_pkg::command_e      reqCommand,
  output logic                              reqPipelined,
  output logic                              reqSmmMode,
  output logic [31:0]                       reqAddr,
  output logic                              host_addr_bit_sixteen
);
  initial begin
    reqValid = 1'b0;
    reqSource = bridge_decoder_pkg::SRC_HOST;
    reqCommand = bridge_decoder_pkg::CMD_MEM_READ;
    reqPipelined = 1'b0;
    reqSmmMode = 1'b0;
    reqAddr = 32'h0;
    host_addr_bit_sixteen = 1'b0;
  end

  // one address phase; returns at the edge that takes it
  task automatic issue(input bridge_decoder_pkg::source_e s, input bridge_decoder_pkg::command_e c,
                       input logic p, input logic [31:0] a, input int unsigned n);
    @(posedge clock);
    reqValid <= 1'b1;
    reqSource <= s;
    reqCommand <= c;
    reqPipelined <= p;
    reqAddr <= a;
    host_addr_bit_sixteen <= (c == bridge_decoder_pkg::CMD_IO_READ ||
                              c == bridge_decoder_pkg::CMD_IO_WRITE) &&
                             (({1'b0, a[15:0]} + 17'(n)) > 17'h1_0000);
    @(posedge clock);
    // released lines must not keep looking valid
    reqValid <= 1'b0;
    reqAddr <= ~a;
    host_addr_bit_sixteen <= 1'b0;
  endtask : issue
endmodule : initiator_model

/* File: tb_top.sv */
// self-checking bench for the bridge address decoder
// assumes the initiator model drives the request port and APB comes from here
`timescale 1ns/1ps

module tb_top;
  localparam bridge_decoder_pkg::source_e  HOST = bridge_decoder_pkg::SRC_HOST;
  localparam bridge_decoder_pkg::source_e  PCI = bridge_decoder_pkg::SRC_PCI;
  localparam bridge_decoder_pkg::source_e  GPT = bridge_decoder_pkg::SRC_GPORT;
  localparam bridge_decoder_pkg::command_e MRD = bridge_decoder_pkg::CMD_MEM_READ;
  localparam bridge_decoder_pkg::command_e MWR = bridge_decoder_pkg::CMD_MEM_WRITE;
  localparam bridge_decoder_pkg::command_e IORD = bridge_decoder_pkg::CMD_IO_READ;
  localparam bridge_decoder_pkg::route_e   RNO = bridge_decoder_pkg::ROUTE_NONE;
  localparam bridge_decoder_pkg::route_e   RME = bridge_decoder_pkg::ROUTE_MEMORY;
  localparam bridge_decoder_pkg::route_e   RPC = bridge_decoder_pkg::ROUTE_PCI;
  localparam bridge_decoder_pkg::route_e   RGP = bridge_decoder_pkg::ROUTE_GPORT;

  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, rer;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic reqValid, reqPipelined, reqSmmMode, host_addr_bit_sixteen, routeValid, routeClaim;
  bridge_decoder_pkg::source_e  reqSource;
  bridge_decoder_pkg::command_e reqCommand;
  bridge_decoder_pkg::route_e   routeTarget;
  logic [31:0] reqAddr, routeAddr;
  int mismatches, check_count;

  bridge_address_decoder DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reqValid(reqValid), .reqSource(reqSource), .reqCommand(reqCommand),
    .reqPipelined(reqPipelined), .reqSmmMode(reqSmmMode), .reqAddr(reqAddr),
    .host_addr_bit_sixteen(host_addr_bit_sixteen), .routeValid(routeValid),
    .routeTarget(routeTarget), .routeClaim(routeClaim), .routeAddr(routeAddr));

  initiator_model model (.clock(clock), .reqValid(reqValid), .reqSource(reqSource),
    .reqCommand(reqCommand), .reqPipelined(reqPipelined), .reqSmmMode(reqSmmMode),
    .reqAddr(reqAddr), .host_addr_bit_sixteen(host_addr_bit_sixteen));

  always #2.5 clock = ~clock;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdv = prdata;
    rer = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rt(input bridge_decoder_pkg::source_e s, input bridge_decoder_pkg::command_e c,
                    input logic p, input logic [31:0] a, input int unsigned n,
                    input bridge_decoder_pkg::route_e t, input logic [31:0] ea);
    model.issue(s, c, p, a, n);
    #1;
    chk("routeValid", {31'h0, routeValid}, 32'h1);
    chk("routeTarget", {29'h0, routeTarget}, {29'h0, t});
    chk("routeClaim", {31'h0, routeClaim}, {31'h0, t != RNO});
    chk("routeAddr", routeAddr, ea);
  endtask : rt

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk("io window reset", rdv, 32'h0000_0F00);
    apb(1'b0, 12'h00C, 32'h0);
    chk("control reset", rdv, 32'h0);
    chk("routeValid idle", {31'h0, routeValid}, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    chk("unmapped error", {31'h0, rer}, 32'h1);
    chk("unmapped data", rdv, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_io;
    apb(1'b1, 12'h000, 32'h0000_0302);
    apb(1'b1, 12'h00C, 32'h0000_0018);
    apb(1'b1, 12'h010, 32'h0000_0010);
    apb(1'b1, 12'h004, 32'h080F_0800);
    rt(HOST, IORD, 1'b0, 32'h1FFF, 1, RPC, 32'h1FFF);
    rt(HOST, IORD, 1'b0, 32'h2000, 1, RGP, 32'h2000);
    rt(HOST, IORD, 1'b0, 32'h3FFF, 1, RGP, 32'h3FFF);
    rt(HOST, IORD, 1'b0, 32'h4000, 1, RPC, 32'h4000);
    rt(HOST, IORD, 1'b0, 32'hFFFF, 2, RPC, 32'h1FFFF);
    rt(HOST, IORD, 1'b0, 32'hFFFD, 2, RPC, 32'hFFFD);
    $display("test io window done");
  endtask : t_io

  task automatic t_legacy;
    logic [31:0] ctl [4] = '{32'h18, 32'h19, 32'h1A, 32'h1F};
    bridge_decoder_pkg::route_e exp [4] = '{RGP, RPC, RPC, RPC};
    apb(1'b1, 12'h000, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h00C, ctl[i]);
      rt(HOST, IORD, 1'b0, 32'h03C0, 1, exp[i], 32'h03C0);
      rt(HOST, IORD, 1'b0, 32'h0FDF, 1, exp[i], 32'h0FDF);
    end
    rt(HOST, MRD, 1'b0, 32'h000A_0000, 1, RPC, 32'h000A_0000);
    apb(1'b1, 12'h00C, 32'h1C);
    rt(HOST, IORD, 1'b0, 32'h03B0, 1, RPC, 32'h03B0);
    rt(HOST, IORD, 1'b0, 32'h03C0, 1, RGP, 32'h03C0);
    $display("test legacy done");
  endtask : t_legacy

  task automatic t_mem;
    apb(1'b1, 12'h00C, 32'h18);
    rt(PCI, MRD, 1'b0, 32'h0010_0000, 4, RME, 32'h0010_0000);
    rt(PCI, MRD, 1'b0, 32'h4000_0000, 4, RNO, 32'h4000_0000);
    rt(PCI, MWR, 1'b0, 32'h8000_0000, 4, RGP, 32'h8000_0000);
    rt(PCI, MRD, 1'b0, 32'h8010_0000, 4, RNO, 32'h8010_0000);
    rt(HOST, MWR, 1'b0, 32'h80FF_FFFC, 4, RGP, 32'h80FF_FFFC);
    rt(HOST, MWR, 1'b0, 32'h8100_0000, 4, RPC, 32'h8100_0000);
    rt(GPT, MWR, 1'b0, 32'h4000_0000, 4, RPC, 32'h4000_0000);
    rt(GPT, MRD, 1'b0, 32'h4000_0000, 4, RNO, 32'h4000_0000);
    rt(GPT, MRD, 1'b0, 32'h0010_0000, 4, RME, 32'h0010_0000);
    rt(GPT, IORD, 1'b0, 32'h2000, 1, RNO, 32'h2000);
    rt(GPT, bridge_decoder_pkg::CMD_CONFIG, 1'b0, 32'h2000, 4, RNO, 32'h2000);
    rt(GPT, bridge_decoder_pkg::CMD_SPECIAL, 1'b0, 32'h2000, 4, RNO, 32'h2000);
    rt(GPT, MRD, 1'b1, 32'h4000_0000, 4, bridge_decoder_pkg::ROUTE_DROP, 32'h4000_0000);
    rt(GPT, MWR, 1'b1, 32'h4000_0000, 4, bridge_decoder_pkg::ROUTE_DROP, 32'h4000_0000);
    rt(GPT, MRD, 1'b1, 32'h0010_0000, 4, RME, 32'h0010_0000);
    $display("test memory map done");
  endtask : t_mem

  task automatic t_guard;
    apb(1'b1, 12'h018, 32'h1);
    apb(1'b1, 12'h014, 32'h4000_0001);
    rt(PCI, IORD, 1'b0, 32'h2000, 1, RNO, 32'h2000);
    rt(PCI, MWR, 1'b0, 32'h000A_0000, 4, RNO, 32'h000A_0000);
    rt(GPT, MWR, 1'b0, 32'h000A_0000, 4, bridge_decoder_pkg::ROUTE_DROP, 32'h000A_0000);
    rt(PCI, MRD, 1'b0, 32'h4000_0000, 4, RME, 32'h4000_0000);
    rt(GPT, MRD, 1'b0, 32'h403F_FFFC, 4, RME, 32'h403F_FFFC);
    apb(1'b0, 12'h01C, 32'h0);
    chk("route counts", rdv, 32'h0007_000E);
    apb(1'b0, 12'h020, 32'h0);
    chk("none count", rdv, 32'h0000_0008);
    $display("test guards done");
  endtask : t_guard

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    close_out;
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_io;
    t_legacy;
    t_mem;
    t_guard;
    close_out;
  end
endmodule : tb_top
